// ### qub_regs.vh
// Purpose: constants for the quad UART bridge register bank
// Assumes: 6-bit register space, 8-bit registers
// Notes:   included by its bare name
`ifndef QUB_REGS_VH
`define QUB_REGS_VH
`define QUB_ADDR_W          6
`define QUB_GLB_CLOCK_EN    6'h00
`define QUB_GLB_RESET_SLEEP 6'h01
`define QUB_GLB_IRQ_EN      6'h10
`define QUB_GLB_IRQ_FLAGS   6'h11
`define QUB_IDX_PAGE        4'h3
`define QUB_IDX_FIFO_PORT   4'hd
`define QUB_IDX_RO_FIRST    4'h9
`define QUB_IDX_RO_LAST     4'hc
`define QUB_IDX_P1_LAST     4'h8
`define QUB_CHAN_HI         5
`define QUB_CHAN_LO         4
`define QUB_PAGE_BIT        0
`define QUB_CLOCK_EN_RST    8'h30
`define QUB_CLOCK_EN_RO     8'h30
`define QUB_IRQ_EN_MASK     8'h1f
`define QUB_CMD_READ_BIT    7
`define QUB_BURST_MAX       9'h100
`define QUB_TXF_DEPTH       16
`define QUB_TXF_AW          4
`define QUB_TXF_W           10
`endif

// ### qub_fifo.v
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two equal to 2**AW
// Notes:   full and empty come from a fill counter
`timescale 1ns/1ps
module qub_fifo #(
   parameter W     = 10,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire         i_clock,
   input  wire         i_srst,
   input  wire         i_in_valid,
   output wire         o_in_ready,
   input  wire [W-1:0] i_in_data,
   output wire         o_out_valid,
   input  wire         i_out_ready,
   output wire [W-1:0] o_out_data,
   output wire [AW:0]  o_count
);
   reg  [W-1:0] mem_q [0:DEPTH-1];
   reg  [AW-1:0] wr_q;
   reg  [AW-1:0] rd_q;
   reg  [AW:0]   cnt_q;
   wire          push;
   wire          pop;

   assign o_in_ready  = (cnt_q != DEPTH[AW:0]);
   assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
   assign o_out_data  = mem_q[rd_q];
   assign o_count     = cnt_q;
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   always @(posedge i_clock) begin
      if (push) begin
         mem_q[wr_q] <= i_in_data;
      end
   end

   always @(posedge i_clock) begin
      if (i_srst) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // qub_fifo

// ### qub_bridge.v
// Purpose: SPI slave front end, address decode and global registers
//          of a four-channel UART bridge
// Assumes: SPI pins are asynchronous and are oversampled by i_clock
// Notes:   channel datapath lives outside; it is reached through the
//          o_chan_* strobes and answers combinationally on i_chan_rdata
// How it works
// - Six-bit address splits global and channel space
// - Four global registers at fixed addresses
// - Global interrupt flags are read-only
// - Top two bits channel, low four index
// - Channel codes 0..3 reach UART 1..4
// - Page register shared, other indices paged
// - Page 0 indices 4..13 channel registers
// - Counts and status indices 9..12 read-only
// - Page 1 indices 4..8 baud and triggers
// - Low clock-enable bits gate channel clocks
// - Upper clock-enable bits read 0011
// - Upper reset bits show channel sleep
// - Low reset bits pulse soft reset, read 0
// - Interrupt output active high
// - Low reset pin resets whole device
// - SPI slave mode 0 only
// - Bursts carry at most 256 data bytes
// - Per-channel 256-entry FIFOs with triggers
// - Receivers flag parity, frame, overrun, break
// - Optional infrared encoding up to 115.2k
// - Receive timeout and break interrupts exist
// - Page bit 0 selects page 0 or 1
// - Data port write pushes, read pops
// - Global flags mirror channel pending interrupts
`timescale 1ns/1ps
`include "qub_regs.vh"
module qub_bridge (
   input  wire       i_clock,
   input  wire       i_srst,
   input  wire       i_rst_n,
   input  wire       i_spi_clk,
   input  wire       i_spi_select_in_n,
   input  wire       i_spi_data_in,
   output wire       o_spi_data_out,
   output wire       o_spi_data_out_oe,
   output wire       o_irq,
   output wire [3:0] o_chan_clock_on,
   output wire [3:0] o_chan_soft_reset,
   input  wire [3:0] i_chan_asleep,
   input  wire [3:0] i_chan_irq_pending,
   output wire       o_chan_wr,
   output wire       o_chan_rd,
   output wire [1:0] o_chan_sel,
   output wire       o_chan_page,
   output wire [3:0] o_chan_index,
   output wire [7:0] o_chan_wdata,
   input  wire [7:0] i_chan_rdata,
   output wire       o_tx_fifo_ready,
   output wire       o_tx_valid,
   input  wire       i_tx_ready,
   output wire [1:0] o_tx_chan,
   output wire [7:0] o_tx_data,
   output wire       o_device_rst
);
   // Decode helpers for the read and the write paths; only is_global serves both
   function is_global;
      input [5:0] a;
      begin
         is_global = (a == `QUB_GLB_CLOCK_EN) || (a == `QUB_GLB_RESET_SLEEP) ||
                     (a == `QUB_GLB_IRQ_EN) || (a == `QUB_GLB_IRQ_FLAGS);
      end
   endfunction

   function chan_writable;
      input [3:0] idx;
      input       pg;
      begin
         if (idx == `QUB_IDX_PAGE) begin
            chan_writable = 1'b0;
         end else if (pg) begin
            chan_writable = (idx > `QUB_IDX_PAGE) && (idx <= `QUB_IDX_P1_LAST);
         end else begin
            chan_writable = (idx > `QUB_IDX_PAGE) && (idx < `QUB_IDX_RO_FIRST);
         end
      end
   endfunction

   function chan_readable;
      input [3:0] idx;
      input       pg;
      begin
         if (pg) begin
            chan_readable = (idx > `QUB_IDX_PAGE) && (idx <= `QUB_IDX_P1_LAST);
         end else begin
            chan_readable = (idx > `QUB_IDX_PAGE) && (idx <= `QUB_IDX_FIFO_PORT);
         end
      end
   endfunction

   // Pin synchronisers; first stage feeds only the second
   reg  [1:0] rstn_sync_q;
   reg  [1:0] clk_sync_q;
   reg  [1:0] sel_sync_q;
   reg  [1:0] din_sync_q;
   reg        clk_prev_q;
   wire       rst;
   wire       spi_rise;
   wire       spi_fall;
   wire       selected;

   always @(posedge i_clock) begin
      if (i_srst) begin
         rstn_sync_q <= 2'h0;
         clk_sync_q  <= 2'h0;
         sel_sync_q  <= 2'h3;
         din_sync_q  <= 2'h0;
         clk_prev_q  <= 1'b0;
      end else begin
         rstn_sync_q <= {rstn_sync_q[0], i_rst_n};
         clk_sync_q  <= {clk_sync_q[0], i_spi_clk};
         sel_sync_q  <= {sel_sync_q[0], i_spi_select_in_n};
         din_sync_q  <= {din_sync_q[0], i_spi_data_in};
         clk_prev_q  <= clk_sync_q[1];
      end
   end

   assign rst          = i_srst | ~rstn_sync_q[1];
   assign o_device_rst = rst;
   assign selected     = ~sel_sync_q[1];
   // Mode 0: sample on rising, shift out on falling edge
   assign spi_rise     = selected & clk_sync_q[1] & ~clk_prev_q;
   assign spi_fall     = selected & ~clk_sync_q[1] & clk_prev_q;

   // Frame state
   reg  [2:0] bit_cnt_q;
   reg  [6:0] rx_shift_q;
   reg        have_cmd_q;
   reg  [7:0] cmd_q;
   reg  [8:0] byte_cnt_q;
   reg  [7:0] tx_shift_q;
   reg        miso_q;
   wire [7:0] rx_byte;
   wire       byte_done;
   wire       is_read;
   wire [5:0] addr;
   wire       in_burst;
   wire       next_in_burst;

   assign rx_byte   = {rx_shift_q, din_sync_q[1]};
   assign byte_done = spi_rise & (bit_cnt_q == 3'h7);
   assign is_read   = cmd_q[`QUB_CMD_READ_BIT];
   // The command byte is not latched yet at its own last edge, so the
   // decode looks at the incoming byte there; the first read value and
   // the channel fields then already show the requested address
   assign addr      = have_cmd_q ? cmd_q[`QUB_ADDR_W-1:0] : rx_byte[`QUB_ADDR_W-1:0];
   assign in_burst  = (byte_cnt_q < `QUB_BURST_MAX);
   // Bytes past the burst limit shift out zeros
   assign next_in_burst = ~have_cmd_q | (byte_cnt_q < (`QUB_BURST_MAX - 9'h001));

   // Register state
   reg  [3:0] clock_on_q;
   reg  [4:0] irq_en_q;
   reg  [3:0] page_q;
   reg  [3:0] soft_rst_q;
   reg  [7:0] rdata;
   wire [1:0] chan;
   wire [3:0] idx;
   wire       page;
   wire       glb;
   wire       commit_wr;
   wire       start_rd;
   wire       data_port;
   wire       txf_in_ready;

   assign chan      = addr[`QUB_CHAN_HI:`QUB_CHAN_LO];
   assign idx       = addr[3:0];
   assign page      = page_q[chan];
   assign glb       = is_global(addr);
   assign data_port = ~page & (idx == `QUB_IDX_FIFO_PORT);
   assign commit_wr = byte_done & have_cmd_q & ~is_read & in_burst;
   // Read side effects fire once the master clocks the first bit of a byte
   assign start_rd  = spi_rise & (bit_cnt_q == 3'h0) & have_cmd_q & is_read & in_burst;

   always @(posedge i_clock) begin
      if (rst || !selected) begin
         bit_cnt_q  <= 3'h0;
         rx_shift_q <= 7'h00;
         have_cmd_q <= 1'b0;
         cmd_q      <= 8'h00;
         byte_cnt_q <= 9'h000;
      end else if (spi_rise) begin
         bit_cnt_q  <= bit_cnt_q + 3'h1;
         rx_shift_q <= rx_byte[6:0];
         if (byte_done) begin
            if (!have_cmd_q) begin
               have_cmd_q <= 1'b1;
               cmd_q      <= rx_byte;
            end else if (in_burst) begin
               byte_cnt_q <= byte_cnt_q + 9'h001;
            end
         end
      end
   end

   // Read mux; write-only bits and reserved bits other than the clock-enable constants read as zero
   always @* begin
      rdata = 8'h00;
      if (glb) begin
         case (addr)
            `QUB_GLB_CLOCK_EN:    rdata = `QUB_CLOCK_EN_RO | {4'h0, clock_on_q};
            `QUB_GLB_RESET_SLEEP: rdata = {i_chan_asleep, 4'h0};
            `QUB_GLB_IRQ_EN:      rdata = {3'h0, irq_en_q};
            `QUB_GLB_IRQ_FLAGS:   rdata = {4'h0, i_chan_irq_pending};
            default:              rdata = 8'h00;
         endcase
      end else if (idx == `QUB_IDX_PAGE) begin
         rdata = {7'h00, page};
      end else if (chan_readable(idx, page)) begin
         rdata = i_chan_rdata;
      end
   end

   // MISO: value is loaded as a byte boundary passes, shifted on falling edges
   always @(posedge i_clock) begin
      if (rst || !selected) begin
         tx_shift_q <= 8'h00;
         miso_q     <= 1'b0;
      end else if (byte_done) begin
         if ((have_cmd_q || rx_byte[`QUB_CMD_READ_BIT]) && !(have_cmd_q && !is_read) &&
             next_in_burst) begin
            tx_shift_q <= rdata;
         end else begin
            tx_shift_q <= 8'h00;
         end
      end else if (spi_fall) begin
         miso_q     <= tx_shift_q[7];
         tx_shift_q <= {tx_shift_q[6:0], 1'b0};
      end
   end

   // Reset and mask words are cut to the register widths on purpose;
   // the reserved clock-enable bits are constants and never stored
   wire [7:0] clock_en_rst;
   wire [7:0] irq_en_mask;
   assign clock_en_rst = `QUB_CLOCK_EN_RST;
   assign irq_en_mask  = `QUB_IRQ_EN_MASK;

   // Global register writes
   always @(posedge i_clock) begin
      if (rst) begin
         clock_on_q <= clock_en_rst[3:0];
         irq_en_q   <= 5'h00;
         soft_rst_q <= 4'h0;
      end else begin
         soft_rst_q <= 4'h0;
         if (commit_wr && glb) begin
            case (addr)
               `QUB_GLB_CLOCK_EN:    clock_on_q <= rx_byte[3:0];
               `QUB_GLB_RESET_SLEEP: soft_rst_q <= rx_byte[3:0];
               `QUB_GLB_IRQ_EN:      irq_en_q   <= rx_byte[4:0] & irq_en_mask[4:0];
               default:              irq_en_q   <= irq_en_q;
            endcase
         end
      end
   end

   // Page bits, cleared by a channel soft reset as well
   integer k;
   always @(posedge i_clock) begin
      if (rst) begin
         page_q <= 4'h0;
      end else begin
         for (k = 0; k < 4; k = k + 1) begin
            if (soft_rst_q[k]) begin
               page_q[k] <= 1'b0;
            end
         end
         if (commit_wr && !glb && idx == `QUB_IDX_PAGE) begin
            page_q[chan] <= rx_byte[`QUB_PAGE_BIT];
         end
      end
   end

   // Channel strobes: one-cycle pulses, fields from the latched command
   reg       chan_wr_q;
   reg       chan_rd_q;
   reg [7:0] wdata_q;
   always @(posedge i_clock) begin
      if (rst) begin
         chan_wr_q <= 1'b0;
         chan_rd_q <= 1'b0;
         wdata_q   <= 8'h00;
      end else begin
         chan_wr_q <= commit_wr & ~glb & ~data_port & chan_writable(idx, page);
         chan_rd_q <= start_rd & ~glb & chan_readable(idx, page);
         if (commit_wr) begin
            wdata_q <= rx_byte;
         end
      end
   end

   // Transmit path buffer; a write while full is dropped
   wire txf_push;
   assign txf_push = commit_wr & ~glb & data_port;
   qub_fifo #(
      .W     (`QUB_TXF_W),
      .DEPTH (`QUB_TXF_DEPTH),
      .AW    (`QUB_TXF_AW)
   ) u_txf (
      .i_clock     (i_clock),
      .i_srst      (rst),
      .i_in_valid  (txf_push),
      .o_in_ready  (txf_in_ready),
      .i_in_data   ({chan, rx_byte}),
      .o_out_valid (o_tx_valid),
      .i_out_ready (i_tx_ready),
      .o_out_data  ({o_tx_chan, o_tx_data}),
      .o_count     ()
   );

   // Interrupt output, registered so the pin cannot glitch while
   // pending and enable bits change in the same cycle
   reg irq_q;
   always @(posedge i_clock) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(i_chan_irq_pending & irq_en_q[3:0]);
      end
   end

   assign o_irq             = irq_q;
   assign o_chan_clock_on   = clock_on_q;
   assign o_chan_soft_reset = soft_rst_q;
   assign o_chan_wr         = chan_wr_q;
   assign o_chan_rd         = chan_rd_q;
   // Channel fields follow the decode address and stand with every strobe
   assign o_chan_sel        = chan;
   assign o_chan_page       = page;
   assign o_chan_index      = idx;
   assign o_chan_wdata      = wdata_q;
   assign o_tx_fifo_ready   = txf_in_ready;
   assign o_spi_data_out    = miso_q;
   assign o_spi_data_out_oe = selected & have_cmd_q & is_read;
endmodule // qub_bridge

// ### qub_spi_host.sv
// Purpose: SPI master model that faces the bridge's host port
// Assumes: mode 0, clock idles low, four system clocks a half bit
// Notes:   one frame is a command byte plus n equal-spaced data bytes, at most 256
`timescale 1ns/1ps
module qub_spi_host (
   input  wire i_clock,
   input  wire i_miso,
   output reg  o_sclk,
   output reg  o_cs_n,
   output reg  o_mosi
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end
   // 200 ns bit time keeps well under the host port's speed ceiling
   task half;
      repeat (4) @(posedge i_clock);
   endtask
   task xbyte(input [7:0] b, output [7:0] r);
      integer k;
      for (k = 7; k >= 0; k = k - 1) begin
         o_mosi <= b[k];
         half;
         r[k] = i_miso;
         o_sclk <= 1'b1;
         half;
         o_sclk <= 1'b0;
      end
   endtask
   task frame(input [7:0] cmd, input [7:0] wd, input integer n, output [7:0] r);
      integer j;
      begin
         @(posedge i_clock);
         o_cs_n <= 1'b0;
         xbyte(cmd, r);
         for (j = 0; j < n && j < 256; j = j + 1) begin
            xbyte(wd + j[7:0], r);
         end
         half;
         o_cs_n <= 1'b1;
         // Released line must not keep showing the last bit
         o_mosi <= ~o_mosi;
         half;
      end
   endtask
endmodule // qub_spi_host

// ### qub_bridge_asserts.sv
// Purpose: port-level assertions for the bridge register bank
// Assumes: one clock domain, i_clock
// Notes:   reset behaviour is checked without a disable condition
`timescale 1ns/1ps
module qub_bridge_asserts (
   input wire       i_clock,
   input wire       i_rst_n,
   input wire       i_spi_select_in_n,
   input wire       o_spi_data_out_oe,
   input wire       o_irq,
   input wire [3:0] i_chan_irq_pending,
   input wire [3:0] o_chan_clock_on,
   input wire [3:0] o_chan_soft_reset,
   input wire       o_chan_wr,
   input wire       o_chan_rd,
   input wire       o_chan_page,
   input wire [3:0] o_chan_index,
   input wire       o_tx_valid,
   input wire       i_tx_ready,
   input wire [1:0] o_tx_chan,
   input wire [7:0] o_tx_data,
   input wire       o_device_rst
);
   default clocking cb @(posedge i_clock); endclocking
   sequence s_stall;
      o_tx_valid && !i_tx_ready;
   endsequence
   sequence s_pin_low;
      !i_rst_n [*4];
   endsequence
   AST_IRQ_CAUSE: assert property (disable iff (o_device_rst)
      o_irq |-> $past(|i_chan_irq_pending)) else $error("irq with no channel pending");
   AST_RST_QUIET: assert property (o_device_rst [*2] |->
      o_chan_clock_on == 4'h0 && !o_irq && o_chan_soft_reset == 4'h0 && !o_tx_valid)
      else $error("outputs active in reset");
   AST_PIN_RESET: assert property (s_pin_low |-> o_device_rst)
      else $error("reset pin ignored");
   AST_SOFT_PULSE: assert property (disable iff (o_device_rst)
      o_chan_soft_reset != 4'h0 |=> o_chan_soft_reset == 4'h0) else $error("soft reset held");
   AST_WR_PULSE: assert property (disable iff (o_device_rst)
      o_chan_wr |-> !o_chan_rd ##1 !o_chan_wr) else $error("write strobe malformed");
   AST_WR_MAP: assert property (disable iff (o_device_rst) o_chan_wr |->
      o_chan_index > 4'h3 && o_chan_index <= (o_chan_page ? 4'h8 : 4'hd) &&
      !(!o_chan_page && o_chan_index >= 4'h9 && o_chan_index <= 4'hc))
      else $error("write to unmapped or read-only index");
   AST_RD_MAP: assert property (disable iff (o_device_rst) o_chan_rd |->
      o_chan_index > 4'h3 && o_chan_index <= (o_chan_page ? 4'h8 : 4'hd) ##1 !o_chan_rd)
      else $error("read strobe malformed");
   AST_IDLE_LINK: assert property (disable iff (o_device_rst)
      i_spi_select_in_n [*6] |-> !o_spi_data_out_oe && !o_chan_wr && !o_chan_rd)
      else $error("activity while deselected");
   AST_TX_HOLD: assert property (disable iff (o_device_rst)
      s_stall |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_chan))
      else $error("stalled buffer output changed");
endmodule // qub_bridge_asserts
bind qub_bridge qub_bridge_asserts u_asserts (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_spi_select_in_n(i_spi_select_in_n),
   .o_spi_data_out_oe(o_spi_data_out_oe), .o_irq(o_irq),
   .i_chan_irq_pending(i_chan_irq_pending), .o_chan_clock_on(o_chan_clock_on),
   .o_chan_soft_reset(o_chan_soft_reset), .o_chan_wr(o_chan_wr), .o_chan_rd(o_chan_rd),
   .o_chan_page(o_chan_page), .o_chan_index(o_chan_index), .o_tx_valid(o_tx_valid),
   .i_tx_ready(i_tx_ready), .o_tx_chan(o_tx_chan), .o_tx_data(o_tx_data),
   .o_device_rst(o_device_rst));

// ### qub_bridge_tb.sv
// Purpose: self-checking bench for the bridge register bank
// Assumes: host model runs the link at 5 Mbit/s
// Notes:   channel logic is mimicked by echoing the decoded address
`timescale 1ns/1ps
module qub_bridge_tb;
   reg        clk, srst, rst_n, tx_rdy;
   reg  [3:0] asleep, pend, sr_seen;
   reg  [7:0] r, wd_seen;
   wire       sclk, cs_n, mosi, miso, miso_q, oe, irq, chan_wr, chan_rd, page;
   wire       tx_v, tx_fr, dev_rst;
   wire [3:0] clk_on, soft_p, idx;
   wire [1:0] sel, tx_chan;
   wire [7:0] wdata, rdata, tx_data;
   integer    miscompares, n_checks, wr_cnt, rd_cnt, drained, c, k;
   always #12.5 clk = ~clk;
   // Answer encodes channel, page and index so reads prove the decode
   assign rdata = {sel, page, 1'b0, idx};
   // A released line shows the inverse, so sampling it too early fails
   assign miso  = oe ? miso_q : ~miso_q;
   qub_spi_host u_host (.i_clock(clk), .i_miso(miso), .o_sclk(sclk), .o_cs_n(cs_n),
      .o_mosi(mosi));
   qub_bridge DUT (.i_clock(clk), .i_srst(srst), .i_rst_n(rst_n), .i_spi_clk(sclk),
      .i_spi_select_in_n(cs_n), .i_spi_data_in(mosi), .o_spi_data_out(miso_q),
      .o_spi_data_out_oe(oe), .o_irq(irq), .o_chan_clock_on(clk_on),
      .o_chan_soft_reset(soft_p), .i_chan_asleep(asleep), .i_chan_irq_pending(pend),
      .o_chan_wr(chan_wr), .o_chan_rd(chan_rd), .o_chan_sel(sel), .o_chan_page(page),
      .o_chan_index(idx), .o_chan_wdata(wdata), .i_chan_rdata(rdata),
      .o_tx_fifo_ready(tx_fr), .o_tx_valid(tx_v), .i_tx_ready(tx_rdy),
      .o_tx_chan(tx_chan), .o_tx_data(tx_data), .o_device_rst(dev_rst));
   task check(input [7:0] got, input [7:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task reg_wr(input [5:0] a, input [7:0] d);
      u_host.frame({2'b00, a}, d, 1, r);
   endtask
   task reg_rd(input [5:0] a, input [7:0] exp);
      begin
         u_host.frame({2'b10, a}, 8'h00, 1, r);
         check(r, exp);
      end
   endtask
   task end_of_test;
      begin
         $display("checks=%0d miscompares=%0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      if (chan_wr) wr_cnt <= wr_cnt + 1;
      if (chan_wr) wd_seen <= wdata;
      if (chan_rd) rd_cnt <= rd_cnt + 1;
      // Cleared in reset so the unknown first cycle does not stick
      sr_seen <= dev_rst ? 4'h0 : (sr_seen | soft_p);
      if (tx_v && tx_rdy) begin
         check(tx_data, 8'h40 + drained[7:0]);
         check({6'h0, tx_chan}, 8'h00);
         drained <= drained + 1;
      end
   end
   initial begin
      clk = 1'b0; srst = 1'b1; rst_n = 1'b1; tx_rdy = 1'b0; asleep = 4'h0; pend = 4'h0;
      sr_seen = 4'h0; miscompares = 0; n_checks = 0; wr_cnt = 0; drained = 0; rd_cnt = 0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      repeat (8) @(posedge clk);
      check({4'h0, clk_on}, 8'h00);
      reg_rd(6'h00, 8'h30);
      reg_wr(6'h00, 8'hff);
      reg_rd(6'h00, 8'h3f);
      check({4'h0, clk_on}, 8'h0f);
      reg_wr(6'h00, 8'h05);
      check({4'h0, clk_on}, 8'h05);
      asleep <= 4'ha;
      reg_wr(6'h01, 8'h0c);
      reg_rd(6'h01, 8'ha0);
      check({4'h0, sr_seen}, 8'h0c);
      pend <= 4'h6;
      reg_wr(6'h11, 8'hff);
      reg_rd(6'h11, 8'h06);
      check({7'h0, irq}, 8'h00);
      reg_wr(6'h10, 8'h04);
      check({7'h0, irq}, 8'h01);
      reg_rd(6'h10, 8'h04);
      pend <= 4'h2;
      repeat (2) @(posedge clk);
      check({7'h0, irq}, 8'h00);
      for (c = 0; c < 4; c = c + 1) begin
         reg_wr({c[1:0], 4'h3}, 8'h01);
         reg_rd({c[1:0], 4'h3}, 8'h01);
         reg_rd({c[1:0], 4'h7}, {c[1:0], 2'b10, 4'h7});
         reg_wr({c[1:0], 4'h3}, 8'h00);
         reg_rd({c[1:0], 4'hc}, {c[1:0], 2'b00, 4'hc});
      end
      check(rd_cnt[7:0], 8'h08);
      k = wr_cnt;
      reg_wr(6'h09, 8'h11);
      check(wr_cnt[7:0], k[7:0]);
      reg_wr(6'h24, 8'h11);
      check(wr_cnt[7:0], k[7:0] + 8'h01);
      check(wd_seen, 8'h11);
      u_host.frame(8'h0d, 8'h40, 17, r);
      check({7'h0, tx_fr}, 8'h00);
      tx_rdy <= 1'b1;
      repeat (40) @(posedge clk);
      check(drained[7:0], 8'h10);
      check({7'h0, tx_fr}, 8'h01);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      check({4'h0, clk_on}, 8'h00);
      reg_rd(6'h00, 8'h30);
      end_of_test;
   end
   initial begin
      #1000000;
      miscompares = miscompares + 1;
      end_of_test;
   end
endmodule // qub_bridge_tb
